// ===== ptc_checker.sv
// Transmit-path pattern checker with counters, snapshots and interrupt logic.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module ptc_checker #(
    parameter int LOCK_GOOD = ptc_pkg::PTC_LOCK_GOOD,
    parameter int LOSS_BAD  = ptc_pkg::PTC_LOSS_BAD
) (
    // Clock, reset and clock enable
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Register port
    input  wire ptc_pkg::ptc_req_s req,
    output logic            [15:0] rdata,
    // Pattern byte stream from the reverse loop
    input  wire ptc_pkg::ptc_byte_s pat,
    // Interrupt
    output logic                   irq_o
);
    import ptc_pkg::*;

    logic        rst_meta_q;
    logic        rst_sync_n;
    logic        en_q;
    logic        mode_q;
    ptc_sync_e   sync_q;
    logic [2:0]  good_q;
    logic [2:0]  bad_q;
    logic        have_prev_q;
    logic [7:0]  prev_q;
    logic [7:0]  expect_byte;
    logic [15:0] total_q;
    logic [7:0]  err_q;
    logic [15:0] total_snap_q;
    logic [7:0]  err_snap_q;
    logic        ovf_q;
    logic        loss_q;
    logic [2:0]  sts_q;
    logic [2:0]  mask_q;
    logic [15:0] rdata_q;
    logic        byte_fire;
    logic        match;
    logic        locked;
    logic        loss_evt;
    logic        lock_evt;
    logic        ovf_evt;
    logic        ctrl_wr;
    logic        ctrl_rd;
    logic        snap_pulse;
    logic        clr_pulse;
    logic [2:0]  sts_set;

    // Only the release of reset is synchronised; assertion stays asynchronous.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    ptc_prbs_pred u_pred (
        .prev_byte (prev_q),
        .next_byte (expect_byte)
    );

    assign ctrl_wr    = req.wr && req.addr == PTC_OFF_CTRL;
    assign ctrl_rd    = req.rd && req.addr == PTC_OFF_CTRL;
    assign snap_pulse = ctrl_wr && (req.wdata[PTC_CTRL_SNAP_BIT] || req.wdata[PTC_CTRL_SCLR_BIT]);
    assign clr_pulse  = ctrl_wr && req.wdata[PTC_CTRL_SCLR_BIT];
    assign byte_fire  = en_q && pat.valid;
    assign match      = have_prev_q && pat.data == expect_byte;
    assign locked     = sync_q == PTC_LOCKED;

    // Control bits that software writes.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            en_q   <= PTC_CTRL_RST[PTC_CTRL_EN_BIT];
            mode_q <= PTC_CTRL_RST[PTC_CTRL_MODE_BIT];
        end else if (ce && ctrl_wr) begin
            en_q   <= req.wdata[PTC_CTRL_EN_BIT];
            mode_q <= req.wdata[PTC_CTRL_MODE_BIT];
        end
    end

    // Previous received byte, the seed of the next prediction.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            have_prev_q <= 1'b0;
            prev_q      <= 8'h00;
        end else if (ce) begin
            if (!en_q) begin
                have_prev_q <= 1'b0;
            end else if (pat.valid) begin
                have_prev_q <= 1'b1;
                prev_q      <= pat.data;
            end
        end
    end

    // Lock needs a run of good bytes, loss a run of bad ones, so a single
    // corrupted byte is counted as an error without dropping sync.
    always_comb begin
        loss_evt = 1'b0;
        lock_evt = 1'b0;
        if (byte_fire) begin
            case (sync_q)
                PTC_HUNT: begin
                    lock_evt = match && good_q == 3'(LOCK_GOOD - 1);
                end
                PTC_LOCKED: begin
                    loss_evt = !match && bad_q == 3'(LOSS_BAD - 1);
                end
                default: begin
                    loss_evt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync_q <= PTC_HUNT;
            good_q <= 3'h0;
            bad_q  <= 3'h0;
        end else if (ce) begin
            if (!en_q) begin
                sync_q <= PTC_HUNT;
                good_q <= 3'h0;
                bad_q  <= 3'h0;
            end else if (pat.valid) begin
                case (sync_q)
                    PTC_HUNT: begin
                        good_q <= match ? 3'(good_q + 3'h1) : 3'h0;
                        bad_q  <= 3'h0;
                        if (lock_evt) begin
                            sync_q <= PTC_LOCKED;
                            good_q <= 3'h0;
                        end
                    end
                    PTC_LOCKED: begin
                        bad_q <= match ? 3'h0 : 3'(bad_q + 3'h1);
                        if (loss_evt) begin
                            sync_q <= PTC_HUNT;
                            bad_q  <= 3'h0;
                        end
                    end
                    default: begin
                        sync_q <= PTC_HUNT;
                    end
                endcase
            end
        end
    end

    // Total byte tally; a clear and a byte in the same cycle leave one.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            total_q <= PTC_TOTAL_RST;
        end else if (ce) begin
            if (clr_pulse) begin
                total_q <= byte_fire ? 16'h0001 : 16'h0000;
            end else if (byte_fire) begin
                total_q <= ptc_bump(total_q, PTC_TOTAL_MAX, mode_q);
            end
        end
    end

    // Errored bytes are only meaningful once the prediction is trusted.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            err_q <= PTC_ERR_RST;
        end else if (ce) begin
            if (clr_pulse) begin
                err_q <= (byte_fire && locked && !match) ? 8'h01 : 8'h00;
            end else if (byte_fire && locked && !match) begin
                err_q <= 8'(ptc_bump({8'h00, err_q}, {8'h00, PTC_ERR_MAX}, mode_q));
            end
        end
    end

    assign ovf_evt = byte_fire && total_q == PTC_TOTAL_MAX;

    // Overflow is set on the byte that meets a full tally; set beats clear.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ovf_q <= 1'b0;
        end else if (ce) begin
            if (ovf_evt) begin
                ovf_q <= 1'b1;
            end else if (clr_pulse) begin
                ovf_q <= 1'b0;
            end
        end
    end

    // Snapshots give software a coherent pair of counts.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            total_snap_q <= PTC_TOTAL_RST;
            err_snap_q   <= PTC_ERR_RST;
        end else if (ce && snap_pulse) begin
            total_snap_q <= total_q;
            err_snap_q   <= err_q;
        end
    end

    // Latched sync loss; a new loss in the read cycle keeps it set.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            loss_q <= 1'b0;
        end else if (ce) begin
            if (loss_evt) begin
                loss_q <= 1'b1;
            end else if (ctrl_rd && locked) begin
                loss_q <= 1'b0;
            end
        end
    end

    assign sts_set = {lock_evt, ovf_evt, loss_evt};

    // Interrupt status is write-one-to-clear, with events winning.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sts_q  <= PTC_IRQ_RST;
            mask_q <= PTC_IRQ_RST;
        end else if (ce) begin
            if (req.wr && req.addr == PTC_OFF_IRQ_STS) begin
                sts_q <= (sts_q & ~req.wdata[PTC_IRQ_W-1:0]) | sts_set;
            end else begin
                sts_q <= sts_q | sts_set;
            end
            if (req.wr && req.addr == PTC_OFF_IRQ_MASK) begin
                mask_q <= req.wdata[PTC_IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(sts_q & mask_q);

    // Read data stand for exactly one cycle after the strobe.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= 16'h0000;
        end else if (ce) begin
            rdata_q <= 16'h0000;
            if (req.rd) begin
                case (req.addr)
                    PTC_OFF_CTRL: begin
                        rdata_q[PTC_CTRL_ERR_MSB:PTC_CTRL_ERR_LSB] <= err_snap_q;
                        rdata_q[PTC_CTRL_LOSS_BIT] <= loss_q;
                        rdata_q[PTC_CTRL_LOCK_BIT] <= locked;
                        rdata_q[PTC_CTRL_OVF_BIT]  <= ovf_q;
                        rdata_q[PTC_CTRL_MODE_BIT] <= mode_q;
                        rdata_q[PTC_CTRL_EN_BIT]   <= en_q;
                    end
                    PTC_OFF_TOTAL: begin
                        rdata_q <= total_snap_q;
                    end
                    PTC_OFF_IRQ_STS: begin
                        rdata_q <= {13'h0000, sts_q};
                    end
                    PTC_OFF_IRQ_MASK: begin
                        rdata_q <= {13'h0000, mask_q};
                    end
                    default: begin
                        rdata_q <= 16'h0000;
                    end
                endcase
            end
        end
    end

    assign rdata = rdata_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    AST_IDLE_WHEN_OFF: assert property (ce && !en_q |=> sync_q == PTC_HUNT)
        else $error("checker not idle while disabled");
    AST_CONT_WRAP: assert property (ce && mode_q && byte_fire && total_q == 16'hFFFF && !clr_pulse
        |=> total_q == 16'h0000)
        else $error("continuous tally did not wrap");
    AST_ERR_SAT: assert property (ce && !mode_q && err_q == 8'hFF && !clr_pulse |=> err_q == 8'hFF)
        else $error("error tally left saturation");
    AST_SNAP: assert property (ce && snap_pulse |=> total_snap_q == $past(total_q) && err_snap_q == $past(err_q))
        else $error("snapshot missed counter values");
    AST_CLEAR: assert property (ce && clr_pulse && !byte_fire |=> total_q == 16'h0000 && err_q == 8'h00)
        else $error("counters not cleared");
    AST_LOSS_LH: assert property (ce && loss_evt |=> loss_q ##1 (loss_q || $past(ctrl_rd && ce)))
        else $error("sync loss flag not latched");
    AST_LOCK_STS: assert property (ce && ctrl_rd |=> rdata[4] == $past(locked))
        else $error("lock status misreported");
    AST_OVF: assert property (ce && ovf_evt |=> ovf_q)
        else $error("overflow flag not set");
    AST_TOT_READ: assert property (ce && req.rd && req.addr == PTC_OFF_TOTAL |=> rdata == $past(total_snap_q))
        else $error("total tally read wrong");
    AST_TOT_SAT: assert property (ce && !mode_q && total_q == 16'hFFFF && !clr_pulse |=> total_q == 16'hFFFF)
        else $error("total tally left saturation");
    AST_LOSS_CLR: assert property (ce && ctrl_rd && locked && !loss_evt |=> !loss_q)
        else $error("sync loss flag not cleared on read");

    // Apart from the event checks AST_ERR_WRAP and AST_LOSS_IRQ and the read-data check AST_RDATA_IDLE, these are hold checks: they catch a tally or flag
    // that moves on a path its rule does not allow, which the event checks above would let through unnoticed.
    AST_ERR_WRAP: assert property (ce && mode_q && byte_fire && locked && !match && err_q == PTC_ERR_MAX &&
        !clr_pulse |=> err_q == PTC_ERR_RST)
        else $error("continuous error tally did not wrap");
    AST_FREEZE: assert property (!ce |=> $stable(total_q) && $stable(err_q) && $stable(sync_q))
        else $error("state moved while clock enable was low");
    AST_RDATA_IDLE: assert property (ce && !req.rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    AST_NO_ERR_HUNT: assert property (ce && !locked && !clr_pulse |=> err_q == $past(err_q))
        else $error("error tally moved while not locked");
    AST_OVF_HOLD: assert property (ovf_q && !(ce && clr_pulse) |=> ovf_q)
        else $error("overflow flag dropped without a clear");
    AST_LOSS_HOLD: assert property (loss_q && !(ce && ctrl_rd && locked) |=> loss_q)
        else $error("sync loss flag dropped without a read");
    AST_LOCK_RUN: assert property (!locked && !(ce && lock_evt) |=> !locked)
        else $error("lock reported without a run of good bytes");
    AST_LOSS_IRQ: assert property (ce && loss_evt |=> sts_q[PTC_IRQ_LOSS])
        else $error("sync loss did not set its status bit");

    COV_LOCK: cover property (ce && lock_evt);
    COV_LOSS: cover property (ce && loss_evt);
    COV_OVF: cover property (ce && ovf_evt);
    COV_SCLR: cover property (ce && clr_pulse && total_q != 16'h0000);
    COV_ERR_WRAP: cover property (ce && mode_q && byte_fire && locked && !match && err_q == PTC_ERR_MAX);

endmodule

// ===== ptc_pkg.sv
// Shared constants, types and helpers for the transmit-path pattern checker.
package ptc_pkg;

    localparam logic [7:0]  PTC_OFF_CTRL      = 8'h39;
    localparam logic [7:0]  PTC_OFF_TOTAL     = 8'h3A;
    localparam logic [7:0]  PTC_OFF_IRQ_STS   = 8'h3B;
    localparam logic [7:0]  PTC_OFF_IRQ_MASK  = 8'h3C;

    localparam int          PTC_CTRL_EN_BIT   = 0;
    localparam int          PTC_CTRL_MODE_BIT = 1;
    localparam int          PTC_CTRL_OVF_BIT  = 2;
    localparam int          PTC_CTRL_LOCK_BIT = 4;
    localparam int          PTC_CTRL_LOSS_BIT = 5;
    localparam int          PTC_CTRL_ERR_LSB  = 7;
    localparam int          PTC_CTRL_ERR_MSB  = 14;
    localparam int          PTC_CTRL_SNAP_BIT = 7;
    localparam int          PTC_CTRL_SCLR_BIT = 8;

    localparam int          PTC_IRQ_W         = 3;
    localparam int          PTC_IRQ_LOSS      = 0;
    localparam int          PTC_IRQ_OVF       = 1;
    localparam int          PTC_IRQ_LOCK      = 2;

    localparam logic [15:0] PTC_CTRL_RST      = 16'h0000;
    localparam logic [15:0] PTC_TOTAL_RST     = 16'h0000;
    localparam logic [7:0]  PTC_ERR_RST       = 8'h00;
    localparam logic [2:0]  PTC_IRQ_RST       = 3'h0;

    localparam logic [7:0]  PTC_ERR_MAX       = 8'hFF;
    localparam logic [15:0] PTC_TOTAL_MAX     = 16'hFFFF;

    localparam int          PTC_LOCK_GOOD     = 4;
    localparam int          PTC_LOSS_BAD      = 4;
    localparam int          PTC_TAP_A         = 6;
    localparam int          PTC_TAP_B         = 7;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } ptc_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ptc_byte_s;

    typedef enum logic {PTC_HUNT, PTC_LOCKED} ptc_sync_e;

    // Next counter value: wraps in continuous mode, sticks at max in single mode.
    function automatic logic [15:0] ptc_bump(input logic [15:0] val, input logic [15:0] max, input logic cont);
        logic [15:0] nxt;
        nxt = 16'((val + 16'h0001) & max);
        if (!cont && val == max) begin
            nxt = val;
        end
        return nxt;
    endfunction

endpackage

// ===== ptc_prbs_pred.sv
// Predicts the next pattern byte from the previous one for a self-synchronising checker.
`timescale 1ns/1ps
module ptc_prbs_pred #(
    parameter int TAP_A = ptc_pkg::PTC_TAP_A,
    parameter int TAP_B = ptc_pkg::PTC_TAP_B
) (
    // Previous byte, bit 0 is the oldest bit on the line
    input  wire logic [7:0] prev_byte,
    // Byte expected next
    output logic      [7:0] next_byte
);
    import ptc_pkg::*;

    // The recurrence reaches back at most TAP_B bits, so one byte of history suffices.
    always_comb begin
        logic [15:0] hist;
        hist = {8'h00, prev_byte};
        for (int i = 8; i < 16; i++) begin
            hist[i] = hist[i - TAP_A] ^ hist[i - TAP_B];
        end
        next_byte = hist[15:8];
    end

endmodule

// ===== ptc_mac_model.sv
// Pattern source that stands in for the MAC at the far end of the reverse loop.
`timescale 1ns/1ps
module ptc_mac_model (
    // Clock
    input  wire logic          clk,
    // Pattern byte stream towards the checker
    output ptc_pkg::ptc_byte_s pat
);
    import ptc_pkg::*;

    logic [7:0] last_q;

    // Bits run LSB first; each bit is the XOR of the bits six and seven places back.
    function automatic logic [7:0] next_of(input logic [7:0] p);
        logic [15:0] s;
        s = {8'h00, p};
        for (int i = 8; i < 16; i++) begin
            s[i] = s[i-6] ^ s[i-7];
        end
        return s[15:8];
    endfunction

    initial begin
        pat    = '0;
        last_q = 8'hA5;
    end

    task automatic seed(input logic [7:0] b);
        last_q = b;
    endtask

    // Bit 0 never feeds the next prediction, so flipping it costs exactly one errored byte.
    task automatic burst(input int n, input int gap, input int bad_from, input int bad_step, input int bad_to);
        logic [7:0] b;
        logic       bad;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            b      = next_of(last_q);
            last_q = b;
            bad    = (i >= bad_from) && (i < bad_to) && ((i - bad_from) % bad_step == 0);
            pat   <= '{valid: 1'b1, data: b ^ {7'h00, bad}};
            for (int g = 0; g < gap; g++) begin
                @(posedge clk);
                pat <= '{valid: 1'b0, data: ~b ^ 8'(g)};
            end
        end
        @(posedge clk);
        pat <= '{valid: 1'b0, data: ~last_q};
    endtask
endmodule

// ===== tb.sv
// Self-checking testbench for the transmit-path pattern checker.
`timescale 1ns/1ps
module tb;
    import ptc_pkg::*;

    logic        clk;
    logic        rst_n;
    logic        ce;
    ptc_req_s    req;
    logic [15:0] rdata;
    ptc_byte_s   pat;
    logic        irq_o;
    logic        rd_seen;
    logic [31:0] exp_q[$];
    logic [31:0] rng;
    int          n_fail;
    int          n_tests;
    int          n_bytes;

    ptc_checker dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rdata(rdata), .pat(pat), .irq_o(irq_o)
    );
    ptc_mac_model u_mac (.clk(clk), .pat(pat));

    always #50 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
    endtask

    // Each read leaves a masked expectation for the monitor below.
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        exp_q.push_back({m, e});
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: 16'h0000};
    endtask

    task automatic irq_is(input logic e);
        @(negedge clk);
        cmp({15'h0000, irq_o}, {15'h0000, e});
    endtask

    task automatic finish_test();
        $display("Comparisons: %0d, mismatches: %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe, so compare mid-cycle there.
    always @(posedge clk) rd_seen <= req.rd & ce;
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            cmp(rdata & exp_q[0][31:16], exp_q[0][15:0]);
            void'(exp_q.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        req = '0;
        rd_seen = 1'b0;
        rng = 32'hD12BCDDA;
        n_fail = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        irq_is(1'b0);
        rd(PTC_OFF_CTRL, 16'hFFFF, PTC_CTRL_RST);
        rd(PTC_OFF_TOTAL, 16'hFFFF, PTC_TOTAL_RST);
        rd(PTC_OFF_IRQ_STS, 16'hFFFF, 16'h0000);
        rd(8'h00, 16'hFFFF, 16'h0000);
        @(posedge clk);
        ce <= 1'b0;
        wr(PTC_OFF_IRQ_MASK, 16'h0007);
        @(posedge clk);
        ce <= 1'b1;
        rd(PTC_OFF_IRQ_MASK, 16'hFFFF, 16'h0000);
        // Bytes sent while disabled must leave no trace.
        rng = xs(rng);
        u_mac.seed(rng[7:0] | 8'h80);
        u_mac.burst(10, 0, 0, 1, 0);
        wr(PTC_OFF_CTRL, 16'h80FE);
        rd(PTC_OFF_CTRL, 16'hFFFF, 16'h0002);
        rd(PTC_OFF_TOTAL, 16'hFFFF, 16'h0000);
        // Continuous mode, clean stream with random spacing.
        wr(PTC_OFF_CTRL, 16'h0003);
        rng = xs(rng);
        n_bytes = 10 + int'(rng[4:0]);
        rng = xs(rng);
        u_mac.burst(n_bytes, int'(rng[1:0]), 0, 1, 0);
        wr(PTC_OFF_CTRL, 16'h0083);
        rd(PTC_OFF_TOTAL, 16'hFFFF, 16'(n_bytes));
        rd(PTC_OFF_CTRL, 16'hFFFF, 16'h0013);
        u_mac.burst(20, 0, 2, 3, 20);
        wr(PTC_OFF_CTRL, 16'h0103);
        rd(PTC_OFF_CTRL, 16'hFFFF, 16'h0313);
        rd(PTC_OFF_TOTAL, 16'hFFFF, 16'(n_bytes + 20));
        wr(PTC_OFF_CTRL, 16'h0083);
        rd(PTC_OFF_TOTAL, 16'hFFFF, 16'h0000);
        rd(PTC_OFF_CTRL, 16'hFFFF, 16'h0013);
        // Four bad bytes in a row drop the lock.
        u_mac.burst(4, 0, 0, 1, 4);
        rd(PTC_OFF_CTRL, 16'h0037, 16'h0023);
        rd(PTC_OFF_CTRL, 16'h0030, 16'h0020);
        rd(PTC_OFF_IRQ_STS, 16'h0007, 16'h0005);
        irq_is(1'b0);
        wr(PTC_OFF_IRQ_MASK, 16'h0001);
        irq_is(1'b1);
        u_mac.burst(6, 0, 0, 1, 0);
        rd(PTC_OFF_CTRL, 16'h0030, 16'h0030);
        rd(PTC_OFF_CTRL, 16'h0030, 16'h0010);
        wr(PTC_OFF_IRQ_STS, 16'h0007);
        rd(PTC_OFF_IRQ_STS, 16'hFFFF, 16'h0000);
        irq_is(1'b0);
        wr(PTC_OFF_IRQ_MASK, 16'h0000);
        // Continuous mode fills the total tally to the brim, with no overflow yet.
        wr(PTC_OFF_CTRL, 16'h0103);
        u_mac.burst(65535, 0, 0, 1, 0);
        wr(PTC_OFF_CTRL, 16'h0081);
        rd(PTC_OFF_TOTAL, 16'hFFFF, PTC_TOTAL_MAX);
        rd(PTC_OFF_CTRL, 16'h0007, 16'h0001);
        // Single mode: both tallies saturate and the total flags overflow.
        u_mac.burst(620, 0, 10, 2, 610);
        wr(PTC_OFF_CTRL, 16'h0081);
        rd(PTC_OFF_TOTAL, 16'hFFFF, PTC_TOTAL_MAX);
        rd(PTC_OFF_CTRL, 16'hFFFF, 16'h7F95);
        // Back in continuous mode one bad and one good byte wrap both tallies.
        wr(PTC_OFF_CTRL, 16'h0003);
        u_mac.burst(2, 0, 0, 1, 1);
        wr(PTC_OFF_CTRL, 16'h0083);
        rd(PTC_OFF_TOTAL, 16'hFFFF, 16'h0001);
        rd(PTC_OFF_CTRL, 16'hFFFF, 16'h0017);
        wr(PTC_OFF_CTRL, 16'h0103);
        wr(PTC_OFF_CTRL, 16'h0083);
        rd(PTC_OFF_CTRL, 16'hFFFF, 16'h0013);
        rd(PTC_OFF_TOTAL, 16'hFFFF, 16'h0000);
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
